// file: core/eeprom_dev.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYC = internal_program_time_typ,
  parameter int unsigned FILT_CYC = NOISE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  twi_if.device                  bus,
  output logic                   prog_busy,
  output logic [ADDR_W-1:0]      cur_addr
);
  typedef enum {st_idle, st_dev, st_word, st_data, st_send, st_rack} dev_state_e;

  if (PROG_CYC < 1 || PROG_CYC >= (1 << TMR_W)) begin : g_bad_prog
    $error("PROG_CYC out of range");
  end
  if (FILT_CYC < 1 || FILT_CYC > 255) begin : g_bad_filt
    $error("FILT_CYC out of range");
  end

  logic [1:0] pin_raw;
  logic [1:0] filt;
  assign pin_raw = {bus.scl, bus.sda};

  // two-flop sync then stability filter per line
  for (genvar i = 0; i < 2; i++) begin : g_in
    logic       s1_q;
    logic       s2_q;
    logic       f_q;
    logic       f_d;
    logic [7:0] c_q;
    logic [7:0] c_d;
    always_comb begin
      f_d = f_q;
      c_d = 8'h00;
      if (s2_q != f_q) begin
        c_d = c_q + 8'h01;
        // only a level held this long counts as an edge
        if (c_q == 8'(FILT_CYC - 1)) begin
          f_d = s2_q;
          c_d = 8'h00;
        end
      end
    end
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        f_q  <= 1'b1;
        c_q  <= 8'h00;
      end else begin
        s1_q <= pin_raw[i];
        s2_q <= s1_q;
        f_q  <= f_d;
        c_q  <= c_d;
      end
    end
    assign filt[i] = f_q;
  end

  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  assign scl_f = filt[1];
  assign sda_f = filt[0];

  // bus events from filtered lines
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;

  logic [7:0]        mem_q [MEM_DEPTH];
  dev_state_e        state_q, state_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        shf_q, shf_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic              inack_q, inack_d;
  logic              mack_q, mack_d;
  logic              oe_n_q, oe_n_d;
  logic              pend_q, pend_d;
  logic [TMR_W-1:0]  prog_q, prog_d;
  logic              busy_q, busy_d;
  logic              mem_we;
  logic [7:0]        rd_byte;
  assign rd_byte = mem_q[addr_q];

  // protocol engine: next values
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shf_d   = shf_q;
    addr_d  = addr_q;
    bank_d  = bank_q;
    inack_d = inack_q;
    mack_d  = mack_q;
    oe_n_d  = oe_n_q;
    pend_d  = pend_q;
    prog_d  = prog_q;
    mem_we  = 1'b0;
    if (prog_q != '0) begin
      prog_d = prog_q - TMR_W'(1);
    end
    if (prog_q != '0) begin
      // interface disabled, line released, no ack
      state_d = st_idle;
      oe_n_d  = 1'b1;
      inack_d = 1'b0;
    end else if (start_ev) begin
      state_d = st_dev;
      cnt_d   = 4'h0;
      inack_d = 1'b0;
      oe_n_d  = 1'b1;
    end else if (stop_ev) begin
      state_d = st_idle;
      oe_n_d  = 1'b1;
      inack_d = 1'b0;
      // program cycle launched by write stop
      if (pend_q) begin
        pend_d = 1'b0;
        prog_d = TMR_W'(PROG_CYC);
      end
    end else if (scl_rise) begin
      unique case (state_q)
        st_dev, st_word, st_data: begin
          if (!inack_q && cnt_q < BIT_ACK) begin
            shf_d = {shf_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end
        end
        // sample master ack in ninth slot
        st_rack: mack_d = ~sda_f;
        st_idle, st_send: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        st_dev, st_word, st_data: begin
          if (inack_q) begin
            oe_n_d  = 1'b1;
            inack_d = 1'b0;
            cnt_d   = 4'h0;
          end else if (cnt_q == BIT_ACK) begin
            oe_n_d  = 1'b0;
            inack_d = 1'b1;
            if (state_q == st_dev) begin
              if (shf_q[7:4] == DEV_TYPE) begin
                bank_d  = shf_q[3:1];
                // read direction goes straight to sending
                state_d = shf_q[0] ? st_send : st_word;
              end else begin
                // not our type: stay off the bus
                oe_n_d  = 1'b1;
                inack_d = 1'b0;
                state_d = st_idle;
              end
            end else if (state_q == st_word) begin
              addr_d  = {bank_q, shf_q};
              state_d = st_data;
            end else begin
              mem_we = 1'b1;
              pend_d = 1'b1;
              // page writes roll over inside the low nibble only
              addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + PAGE_W'(1);
            end
          end
        end
        st_send: begin
          if (inack_q) begin
            shf_d   = rd_byte;
            oe_n_d  = rd_byte[7];
            // counter left one past last byte sent
            addr_d  = addr_q + ADDR_W'(1);
            cnt_d   = 4'h1;
            inack_d = 1'b0;
          end else if (cnt_q < BIT_ACK) begin
            oe_n_d = shf_q[6];
            shf_d  = {shf_q[6:0], 1'b1};
            cnt_d  = cnt_q + 4'h1;
          end else begin
            oe_n_d  = 1'b1;
            mack_d  = 1'b0;
            state_d = st_rack;
          end
        end
        st_rack: begin
          if (mack_q) begin
            shf_d   = rd_byte;
            oe_n_d  = rd_byte[7];
            addr_d  = addr_q + ADDR_W'(1);
            cnt_d   = 4'h1;
            state_d = st_send;
          end else begin
            // no ack ends transmission until stop
            oe_n_d  = 1'b1;
            state_d = st_idle;
          end
        end
        st_idle: ;
      endcase
    end
    busy_d = (prog_d != '0);
  end

  // protocol engine: registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= st_idle;
      cnt_q   <= 4'h0;
      shf_q   <= 8'hff;
      addr_q  <= '0;
      bank_q  <= '0;
      inack_q <= 1'b0;
      mack_q  <= 1'b0;
      oe_n_q  <= 1'b1;
      pend_q  <= 1'b0;
      prog_q  <= '0;
      busy_q  <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shf_q   <= shf_d;
      addr_q  <= addr_d;
      bank_q  <= bank_d;
      inack_q <= inack_d;
      mack_q  <= mack_d;
      oe_n_q  <= oe_n_d;
      pend_q  <= pend_d;
      prog_q  <= prog_d;
      busy_q  <= busy_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem_q[addr_q] <= shf_q;
    end
  end

  assign bus.sda_s_oe_n = oe_n_q;
  assign prog_busy      = busy_q;
  assign cur_addr       = addr_q;
endmodule
`default_nettype wire

// file: shared/eeprom_pkg.sv
package eeprom_pkg;
  // clock and array shape
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned CLK_NS   = 20;
  localparam int unsigned ADDR_W   = 11;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam int unsigned PAGE_W   = 4;
  localparam int unsigned BANK_W   = 3;
  localparam logic [3:0]  DEV_TYPE = 4'ha;
  localparam logic [3:0]  BIT_ACK  = 4'h8;
  localparam int unsigned TMR_W    = 20;
  // input noise rejection, least time rounds up
  localparam int unsigned NOISE_NS  = 100;
  localparam int unsigned NOISE_CYC = (NOISE_NS + CLK_NS - 1) / CLK_NS;
  // self-timed write, typical and longest, in ms
  localparam int unsigned PROG_TYP_MS = 5;
  localparam int unsigned PROG_MAX_MS = 10;
  localparam int unsigned internal_program_time_typ = PROG_TYP_MS * (CLK_HZ / 1000);
  localparam int unsigned internal_program_time     = PROG_MAX_MS * (CLK_HZ / 1000);
  // supply-stable to first read, in ms
  localparam int unsigned PUR_MS = 1;
  localparam int unsigned powerup_to_read_delay = PUR_MS * (CLK_HZ / 1000);
  // bus rate and bus-free time
  localparam int unsigned SCL_KHZ  = 100;
  localparam int unsigned QTR_CYC  = CLK_HZ / (SCL_KHZ * 1000 * 4);
  localparam int unsigned BUF_NS   = 4700;
  localparam int unsigned BUF_CYC  = (BUF_NS + CLK_NS - 1) / CLK_NS;
  // host command set
  typedef enum logic [1:0] {op_write, op_read_cur, op_read_rand, op_poll} cmd_op_e;
endpackage

// file: shared/twi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface twi_if;
  logic scl;
  logic sda_m_oe_n;
  logic sda_s_oe_n;
  wire  sda;
  // open drain: any enabled driver pulls low, else pulled up
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport device (input scl, input sda, output sda_s_oe_n);
  modport host (output scl, output sda_m_oe_n, input sda);
endinterface
`default_nettype wire

// file: core/eeprom_host.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host
  import eeprom_pkg::*;
#(
  parameter int unsigned WAIT_CYC = internal_program_time,
  parameter int unsigned PUR_CYC  = powerup_to_read_delay,
  parameter int unsigned PUW_CYC  = powerup_to_read_delay
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  twi_if.host                    bus,
  input  wire logic              cmd_valid,
  input  wire cmd_op_e           cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]        cmd_data,
  input  wire logic [7:0]        cmd_len,
  output logic                   cmd_ready,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   done,
  output logic                   nack
);
  typedef enum {h_idle, h_start, h_dev, h_word, h_data, h_rstart, h_rdev, h_read, h_stop}
    host_state_e;

  if (WAIT_CYC >= (1 << TMR_W) || PUR_CYC >= (1 << TMR_W) || PUW_CYC >= (1 << TMR_W))
  begin : g_bad
    $error("wait counts exceed timer width");
  end
  localparam int unsigned PU_CYC = (PUR_CYC > PUW_CYC) ? PUR_CYC : PUW_CYC;

  logic s1_q;
  logic sda_q;
  host_state_e       hs_q, hs_d;
  logic [1:0]        q_q, q_d;
  logic [7:0]        div_q, div_d;
  logic [3:0]        bit_q, bit_d;
  logic [7:0]        shf_q, shf_d;
  logic              ackd_q, ackd_d;
  logic              scl_q, scl_d;
  logic              oe_n_q, oe_n_d;
  logic [TMR_W-1:0]  wait_q, wait_d;
  cmd_op_e           op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0]        data_q, data_d;
  logic [7:0]        len_q, len_d;
  logic [7:0]        rdd_q, rdd_d;
  logic              rdv_q, rdv_d;
  logic              done_q, done_d;
  logic              nack_q, nack_d;
  logic              rdy_q, rdy_d;
  logic              tick;
  logic              is_tx;
  assign tick  = (div_q == 8'h00);
  assign is_tx = hs_q inside {h_dev, h_word, h_data, h_rdev};

  // bus sequencer: next values
  always_comb begin
    hs_d = hs_q; q_d = q_q; bit_d = bit_q; shf_d = shf_q; ackd_d = ackd_q;
    scl_d = scl_q; oe_n_d = oe_n_q; op_d = op_q; addr_d = addr_q;
    data_d = data_q; len_d = len_q; rdd_d = rdd_q; nack_d = nack_q;
    rdv_d = 1'b0;
    done_d = 1'b0;
    div_d = tick ? 8'(QTR_CYC - 1) : div_q - 8'h01;
    wait_d = (wait_q != '0) ? wait_q - TMR_W'(1) : wait_q;
    if (hs_q == h_idle) begin
      scl_d  = 1'b1;
      oe_n_d = 1'b1;
      if (cmd_valid && rdy_q) begin
        op_d = cmd_op; addr_d = cmd_addr; data_d = cmd_data; len_d = cmd_len;
        nack_d = 1'b0; hs_d = h_start; q_d = 2'h0; bit_d = 4'h0;
        div_d = 8'(QTR_CYC - 1);
      end
    end else if (tick) begin
      q_d = q_q + 2'h1;
      if (q_q == 2'h1) scl_d = 1'b1;
      if (q_q == 2'h3) scl_d = 1'b0;
      if (hs_q == h_start || hs_q == h_rstart) begin
        if (q_q == 2'h0) oe_n_d = 1'b1;
        if (q_q == 2'h2) oe_n_d = 1'b0;
        if (q_q == 2'h3) begin
          bit_d = 4'h0;
          hs_d  = (hs_q == h_start) ? h_dev : h_rdev;
          // current read addresses the device for reading at once
          shf_d = {DEV_TYPE, addr_q[ADDR_W-1:8],
                   (hs_q == h_rstart) || (op_q == op_read_cur)};
        end
      end else if (is_tx) begin
        if (q_q == 2'h0) oe_n_d = (bit_q == BIT_ACK) ? 1'b1 : shf_q[7];
        if (q_q == 2'h2 && bit_q == BIT_ACK) ackd_d = ~sda_q;
        if (q_q == 2'h3) begin
          if (bit_q != BIT_ACK) begin
            shf_d = {shf_q[6:0], 1'b1};
            bit_d = bit_q + 4'h1;
          end else begin
            bit_d = 4'h0;
            if (!ackd_q) begin
              // busy device gives no ack, poll reports it
              nack_d = 1'b1;
              hs_d   = h_stop;
            end else begin
              unique case (hs_q)
                h_dev: begin
                  hs_d  = (op_q == op_poll) ? h_stop :
                          (op_q == op_read_cur) ? h_read : h_word;
                  shf_d = addr_q[7:0];
                end
                h_word: begin
                  hs_d  = (op_q == op_write) ? h_data : h_rstart;
                  shf_d = data_q;
                end
                h_data: hs_d = h_stop;
                default: hs_d = h_read;
              endcase
            end
          end
        end
      end else if (hs_q == h_read) begin
        // ack asks for more; last byte gets nack
        if (q_q == 2'h0) oe_n_d = (bit_q == BIT_ACK) ? (len_q <= 8'h01) : 1'b1;
        if (q_q == 2'h2 && bit_q != BIT_ACK) shf_d = {shf_q[6:0], sda_q};
        if (q_q == 2'h3) begin
          if (bit_q != BIT_ACK) begin
            bit_d = bit_q + 4'h1;
          end else begin
            bit_d = 4'h0;
            rdd_d = shf_q;
            rdv_d = 1'b1;
            len_d = len_q - 8'h01;
            if (len_q <= 8'h01) hs_d = h_stop;
          end
        end
      end else begin
        // stop: data rises while clock stays high
        if (q_q == 2'h0) oe_n_d = 1'b0;
        if (q_q == 2'h2) oe_n_d = 1'b1;
        if (q_q == 2'h3) begin
          scl_d  = 1'b1;
          hs_d   = h_idle;
          done_d = 1'b1;
          // wait out the longest write time after a write
          wait_d = (op_q == op_write && !nack_q) ? TMR_W'(WAIT_CYC) : TMR_W'(BUF_CYC);
        end
      end
    end
    rdy_d = (hs_d == h_idle) && (wait_d == '0) && !(cmd_valid && rdy_q);
  end

  // bus sequencer: registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hs_q <= h_idle; q_q <= 2'h0; div_q <= 8'h00; bit_q <= 4'h0; shf_q <= 8'hff;
      ackd_q <= 1'b0; scl_q <= 1'b1; oe_n_q <= 1'b1;
      // hold off after reset for the power-up delay
      wait_q <= TMR_W'(PU_CYC);
      op_q <= op_write; addr_q <= '0; data_q <= 8'h00; len_q <= 8'h00;
      rdd_q <= 8'h00; rdv_q <= 1'b0; done_q <= 1'b0; nack_q <= 1'b0; rdy_q <= 1'b0;
      s1_q <= 1'b1; sda_q <= 1'b1;
    end else begin
      hs_q <= hs_d; q_q <= q_d; div_q <= div_d; bit_q <= bit_d; shf_q <= shf_d;
      ackd_q <= ackd_d; scl_q <= scl_d; oe_n_q <= oe_n_d; wait_q <= wait_d;
      op_q <= op_d; addr_q <= addr_d; data_q <= data_d; len_q <= len_d;
      rdd_q <= rdd_d; rdv_q <= rdv_d; done_q <= done_d; nack_q <= nack_d; rdy_q <= rdy_d;
      s1_q <= bus.sda; sda_q <= s1_q;
    end
  end

  assign bus.scl        = scl_q;
  assign bus.sda_m_oe_n = oe_n_q;
  assign cmd_ready      = rdy_q;
  assign rd_data        = rdd_q;
  assign rd_valid       = rdv_q;
  assign done           = done_q;
  assign nack           = nack_q;
endmodule
`default_nettype wire

// file: dv/eeprom_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_seq_sva
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYC = internal_program_time_typ
) (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              scl,
  input wire logic              sda_m_oe_n,
  input wire logic              sda_s_oe_n,
  input wire logic              sda,
  input wire logic              prog_busy,
  input wire logic [ADDR_W-1:0] cur_addr
);
  logic [31:0] busy_d;
  logic [31:0] busy_q;
  logic [31:0] low_d;
  logic [31:0] low_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // busy length and time since scl fell; 32 bits never wrap in a run
  always_comb begin
    busy_d = prog_busy ? busy_q + 32'h1 : 32'h0;
    low_d  = scl ? 32'h0 : low_q + 32'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_q <= 32'h0;
      low_q  <= 32'h0;
    end else begin
      busy_q <= busy_d;
      low_q  <= low_d;
    end
  end

  a_busy_sda_free: assert property (prog_busy |-> sda_s_oe_n)
    else $error("device pulls data low while busy");
  a_busy_addr_frozen: assert property ($past(prog_busy) && prog_busy |-> $stable(cur_addr))
    else $error("address counter moved while busy");
  a_busy_at_stop: assert property ($rose(prog_busy) |-> scl && sda)
    else $error("program cycle began without a stop");
  a_busy_min_run: assert property ($rose(prog_busy) |-> prog_busy [*8])
    else $error("program cycle dropped at once");
  a_busy_length: assert property ($fell(prog_busy) |->
      busy_q >= PROG_CYC - 1 && busy_q <= PROG_CYC + 1)
    else $error("program cycle length wrong");
  a_no_clash: assert property (scl |-> sda_m_oe_n || sda_s_oe_n)
    else $error("device drives data in master slot");
  a_drive_window: assert property ($changed(sda_s_oe_n) |->
      !scl && low_q >= 5 && low_q <= 20)
    else $error("device data changed outside scl low");
  a_filter_lag: assert property ($fell(scl) |-> $stable(sda_s_oe_n) [*5])
    else $error("device reacted faster than filter");

  // main scenarios reached
  cover property ($rose(prog_busy));
  cover property (scl && $fell(sda));
  cover property (!scl && $fell(sda_s_oe_n));
endmodule
`default_nettype wire

// file: dv/serial_eeprom_seq_read_write_busy_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_seq_read_write_busy_bench
  import eeprom_pkg::*;
();
  localparam int unsigned PROG_SIM = 8000;
  typedef struct {
    cmd_op_e     op;
    logic [10:0] a;
    logic [7:0]  d;
    logic [7:0]  n;
    logic        wf;
    logic        nk;
  } row_s;

  logic              sys_clk   = 1'b0;
  logic              reset     = 1'b1;
  logic              cmd_valid = 1'b0;
  cmd_op_e           cmd_op    = op_write;
  logic [ADDR_W-1:0] cmd_addr  = 11'h000;
  logic [7:0]        cmd_data  = 8'h00;
  logic [7:0]        cmd_len   = 8'h01;
  logic              cmd_ready;
  logic              rd_valid;
  logic              done;
  logic              nack;
  logic              prog_busy;
  logic [7:0]        rd_data;
  logic [ADDR_W-1:0] cur_addr;
  int                bad_count = 0;
  int                checks    = 0;
  logic [7:0]        rd_q [$];
  // write top and bottom, poll while busy, then read across the wrap
  row_s              rows [4]  = '{
    '{op_write,     11'h7ff, 8'h5a, 8'h01, 1'b0, 1'b0},
    '{op_poll,      11'h000, 8'h00, 8'h01, 1'b0, 1'b1},
    '{op_write,     11'h000, 8'ha5, 8'h01, 1'b1, 1'b0},
    '{op_read_rand, 11'h7ff, 8'h00, 8'h02, 1'b1, 1'b0}};

  twi_if link();

  // short program time keeps the run small; host wait shorter so polling meets busy
  eeprom_dev #(.PROG_CYC(PROG_SIM)) i_eeprom_dev (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .bus       (link),
    .prog_busy (prog_busy),
    .cur_addr  (cur_addr)
  );

  eeprom_host #(.WAIT_CYC(50), .PUR_CYC(50), .PUW_CYC(50)) i_eeprom_host (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .bus       (link),
    .cmd_valid (cmd_valid),
    .cmd_op    (cmd_op),
    .cmd_addr  (cmd_addr),
    .cmd_data  (cmd_data),
    .cmd_len   (cmd_len),
    .cmd_ready (cmd_ready),
    .rd_data   (rd_data),
    .rd_valid  (rd_valid),
    .done      (done),
    .nack      (nack)
  );

  eeprom_seq_sva #(.PROG_CYC(PROG_SIM)) i_eeprom_seq_sva (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .scl        (link.scl),
    .sda_m_oe_n (link.sda_m_oe_n),
    .sda_s_oe_n (link.sda_s_oe_n),
    .sda        (link.sda),
    .prog_busy  (prog_busy),
    .cur_addr   (cur_addr)
  );

  always #10 sys_clk = ~sys_clk;

  // collect every byte the host hands back
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      rd_q.push_back(rd_data);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that takes it, then dropped
  task automatic run_cmd(input row_s r);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
    // a host that never becomes ready counts as a failure
    if (k >= 20000) begin
      bad_count++;
    end
    cmd_op    <= r.op;
    cmd_addr  <= r.a;
    cmd_data  <= r.d;
    cmd_len   <= r.n;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 40000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 40000) begin
      bad_count++;
    end
  endtask

  task automatic wait_free();
    int k;
    k = 0;
    while (prog_busy !== 1'b0 && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 20000) begin
      bad_count++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // reset, table of commands, then wrap, counter and second reset
  initial begin
    repeat (3) @(posedge sys_clk);
    chk(16'({link.scl, link.sda, cmd_ready, prog_busy}), 16'h000c);
    chk(16'(cur_addr), 16'h0000);
    reset <= 1'b0;
    // power-up hold-off: no command accepted this early
    repeat (40) @(posedge sys_clk);
    chk(16'(cmd_ready), 16'h0000);
    foreach (rows[i]) begin
      if (rows[i].wf) begin
        wait_free();
      end
      run_cmd(rows[i]);
      chk(16'(nack), 16'(rows[i].nk));
    end
    chk(16'(rd_q.size()), 16'h0002);
    chk(16'(rd_q[0]), 16'h005a);
    chk(16'(rd_q[1]), 16'h00a5);
    chk(16'(cur_addr), 16'h0001);
    chk(16'(link.sda_s_oe_n), 16'h0001);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(16'({cur_addr, prog_busy}), 16'h0000);
    reset <= 1'b0;
    // array survives reset; current read starts from cleared counter
    run_cmd('{op_read_cur, 11'h000, 8'h00, 8'h01, 1'b0, 1'b0});
    chk(16'(rd_q[2]), 16'h00a5);
    chk(16'(cur_addr), 16'h0001);
    report_and_stop();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (100000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
